// [hdl/tmt_top.sv]
// tick and modulo timers with an APB register slave
// assumes APB master on CLK_I; count pins are asynchronous and are synchronised here
`timescale 1ns/10ps
`default_nettype none

module tmt_top
	import tmt_pkg::*;
#(
	parameter int SYS_DIV    = tmt_pkg::SYS_DIV_CYC,   // core cycles per base tick
	parameter int SLOW_CNT   = tmt_pkg::SLOW_TICKS,    // base ticks per slow tick
	parameter int FAST_CNT   = tmt_pkg::TICK_FAST_CNT  // base ticks per fast interval
) (
	input  wire logic        CLK_I,             // 125 MHz clock
	input  wire logic        RSTN_I,            // async reset, active low
	input  wire logic        PSEL_I,            // apb select
	input  wire logic        PENABLE_I,         // apb enable
	input  wire logic        PWRITE_I,          // apb direction
	input  wire logic [11:0] PADDR_I,           // apb byte address
	input  wire logic [31:0] PWDATA_I,          // apb write data
	output logic      [31:0] PRDATA_O,          // apb read data
	output logic             PREADY_O,          // apb ready
	output logic             PSLVERR_O,         // apb error, unmapped
	input  wire logic        EXT_COUNT_A_I,     // count pin a
	input  wire logic        EXT_COUNT_B_I,     // count pin b
	output logic             TICK_INT_O,        // tick interrupt accepted
	output logic             MOD_INT_O,         // modulo interrupt accepted
	output logic             INTS_DISABLED_O    // interrupts disabled state
);
	import tmt_pkg::*;

	// register state
	logic       slow_flag_r;
	logic       rate_sel_r;
	logic       run_r;
	logic [1:0] sel_r;
	logic [7:0] cnt_r;
	logic [7:0] cmp_r;
	logic       tick_req_r;
	logic       mod_req_r;
	logic       ints_dis_r;
	logic       ie_tick_r;
	logic       ie_mod_r;
	logic       pulse_prev_r;
	logic       ext_a_prev_r;
	logic       ext_b_prev_r;

	// timer base and dividers
	logic       sys_en;
	logic       en_25k;
	logic       slow_evt;
	logic       fast_wrap;
	logic [$clog2(FAST_CNT+1)-1:0]   fast_ph;
	logic [$clog2(TICK_RATIO+1)-1:0] quad_ph;
	logic       ext_a_lvl;
	logic       ext_b_lvl;

	localparam int FW = $clog2(FAST_CNT + 1);
	localparam int QW = $clog2(TICK_RATIO + 1);
	localparam logic [FW-1:0] FAST_HALF = FW'(FAST_CNT / 2);
	localparam logic [QW-1:0] QUAD_HALF = QW'(TICK_RATIO / 2);

	// index hit on an aligned byte address
	function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
		reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
	endfunction : reg_hit

	tmt_div #(.N(SYS_DIV)) u_sys_div (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.en_i   (1'b1),
		.cnt_o  (),
		.tick_o (sys_en)
	);

	tmt_div #(.N(MOD_SLOW_DIV)) u_div25 (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.en_i   (sys_en),
		.cnt_o  (),
		.tick_o (en_25k)
	);

	// slow tick period from the timer base
	tmt_div #(.N(SLOW_CNT)) u_slow_div (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.en_i   (sys_en),
		.cnt_o  (),
		.tick_o (slow_evt)
	);

	// fast interval phase and four of them for the slow interval
	tmt_div #(.N(FAST_CNT)) u_fast_div (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.en_i   (sys_en),
		.cnt_o  (fast_ph),
		.tick_o (fast_wrap)
	);

	tmt_div #(.N(TICK_RATIO)) u_quad_div (
		.clk_i  (CLK_I),
		.rstn_i (RSTN_I),
		.en_i   (fast_wrap),
		.cnt_o  (quad_ph),
		.tick_o ()
	);

	tmt_sync u_sync_a (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.async_i (EXT_COUNT_A_I),
		.level_o (ext_a_lvl)
	);

	tmt_sync u_sync_b (
		.clk_i   (CLK_I),
		.rstn_i  (RSTN_I),
		.async_i (EXT_COUNT_B_I),
		.level_o (ext_b_lvl)
	);

	// apb phases: reads sample and clear on the first access cycle, writes on the last
	logic acc_go;
	logic acc_done;
	logic wr_done;
	logic rd_go;
	assign acc_go   = PSEL_I & PENABLE_I & ~PREADY_O;
	assign acc_done = PSEL_I & PENABLE_I & PREADY_O;
	assign wr_done  = acc_done & PWRITE_I;
	assign rd_go    = acc_go & ~PWRITE_I;

	logic wr_rate;
	logic wr_ctrl;
	logic wr_cmp;
	logic wr_req;
	logic wr_en;
	logic rd_slow;
	assign wr_rate = wr_done & reg_hit(PADDR_I, IDX_RATE_SEL);
	assign wr_ctrl = wr_done & reg_hit(PADDR_I, IDX_MOD_CTRL);
	assign wr_cmp  = wr_done & reg_hit(PADDR_I, IDX_MOD_CMP);
	assign wr_req  = wr_done & reg_hit(PADDR_I, IDX_IRQ_REQ);
	assign wr_en   = wr_done & reg_hit(PADDR_I, IDX_IRQ_EN);
	assign rd_slow = rd_go & reg_hit(PADDR_I, IDX_SLOW_FLAG);

	// read mux and address decode
	logic [31:0] rd_val;
	logic        mapped;
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		if (reg_hit(PADDR_I, IDX_SLOW_FLAG)) begin
			rd_val[0] = slow_flag_r;
		end else if (reg_hit(PADDR_I, IDX_RATE_SEL)) begin
			rd_val[RATE_SEL_BIT] = rate_sel_r;
		end else if (reg_hit(PADDR_I, IDX_MOD_CTRL)) begin
			rd_val[CTRL_RUN_BIT] = run_r;             // clear bit stays zero
			rd_val[CTRL_SEL_HI:CTRL_SEL_LO] = sel_r;
		end else if (reg_hit(PADDR_I, IDX_MOD_CNT)) begin
			rd_val[7:0] = cnt_r;
		end else if (reg_hit(PADDR_I, IDX_MOD_CMP)) begin
			rd_val = 32'h0000_0000;                   // write-only
		end else if (reg_hit(PADDR_I, IDX_IRQ_REQ)) begin
			rd_val[REQ_TICK_BIT] = tick_req_r;
			rd_val[REQ_MOD_BIT]  = mod_req_r;
		end else if (reg_hit(PADDR_I, IDX_IRQ_EN)) begin
			rd_val[EN_ALL_BIT]  = ~ints_dis_r;
			rd_val[EN_TICK_BIT] = ie_tick_r;
			rd_val[EN_MOD_BIT]  = ie_mod_r;
		end else begin
			mapped = 1'b0;
		end
	end

	// apb answer, ready one cycle into the access phase
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= acc_go;
			PSLVERR_O <= acc_go & ~mapped;
			if (rd_go) begin
				PRDATA_O <= rd_val;
			end
		end
	end

	// slow tick flag: set beats the read clear
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			slow_flag_r <= SLOW_FLAG_RST;
		end else if (slow_evt) begin
			slow_flag_r <= 1'b1;
		end else if (rd_slow) begin
			slow_flag_r <= 1'b0;
		end
	end

	// interval pulses, high for the first half of each period
	logic pulse_fast;
	logic pulse_slow;
	logic pulse_sel;
	logic tick_fall;
	assign pulse_fast = (fast_ph < FAST_HALF);
	assign pulse_slow = (quad_ph < QUAD_HALF);
	assign pulse_sel  = rate_sel_r ? pulse_fast : pulse_slow;
	assign tick_fall  = pulse_prev_r & ~pulse_sel;

	// rate select and pulse history
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rate_sel_r   <= RATE_SEL_RST;
			pulse_prev_r <= 1'b1;
		end else begin
			pulse_prev_r <= pulse_sel;
			if (wr_rate) begin
				rate_sel_r <= PWDATA_I[RATE_SEL_BIT];
			end
		end
	end

	// acceptance, tick ahead of modulo
	logic tick_acc;
	logic mod_acc;
	assign tick_acc = tick_req_r & ~ints_dis_r & ie_tick_r;
	assign mod_acc  = mod_req_r & ~ints_dis_r & ie_mod_r & ~tick_acc;

	// tick request: software write first, so a clear beats a fall
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			tick_req_r <= 1'b0;
		end else if (wr_req) begin
			tick_req_r <= PWDATA_I[REQ_TICK_BIT];
		end else if (tick_fall) begin
			tick_req_r <= 1'b1;
		end else if (tick_acc) begin
			tick_req_r <= 1'b0;
		end
	end

	// modulo clock source and edges of the count pins
	logic ext_a_rise;
	logic ext_b_rise;
	logic mod_clk_en;
	assign ext_a_rise = ext_a_lvl & ~ext_a_prev_r;
	assign ext_b_rise = ext_b_lvl & ~ext_b_prev_r;
	always_comb begin
		case (tmt_src_t'(sel_r))
			TMT_SRC_EXT_A: mod_clk_en = ext_a_rise;
			TMT_SRC_EXT_B: mod_clk_en = ext_b_rise;
			TMT_SRC_75K:   mod_clk_en = sys_en;
			default:       mod_clk_en = en_25k;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ext_a_prev_r <= 1'b0;
			ext_b_prev_r <= 1'b0;
		end else begin
			ext_a_prev_r <= ext_a_lvl;
			ext_b_prev_r <= ext_b_lvl;
		end
	end

	// modulo control and compare registers
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			run_r <= CTRL_RUN_RST;
			sel_r <= CTRL_SEL_RST;
			cmp_r <= MOD_CMP_RST;
		end else begin
			if (wr_ctrl) begin
				run_r <= PWDATA_I[CTRL_RUN_BIT];
				sel_r <= PWDATA_I[CTRL_SEL_HI:CTRL_SEL_LO];
			end
			if (wr_cmp) begin
				cmp_r <= PWDATA_I[7:0];
			end
		end
	end

	// modulo counter: clear write, then gated count with match restart
	logic clr_wr;
	logic mod_match;
	assign clr_wr    = wr_ctrl & PWDATA_I[CTRL_CLR_BIT];
	assign mod_match = run_r & mod_clk_en & (cnt_r == cmp_r) & ~clr_wr;
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cnt_r <= MOD_CNT_RST;
		end else if (clr_wr) begin
			cnt_r <= 8'h00;
		end else if (mod_match) begin
			cnt_r <= 8'h00;
		end else if (run_r && mod_clk_en) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// modulo request: a match beats a software or acceptance clear
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mod_req_r <= 1'b0;
		end else if (mod_match) begin
			mod_req_r <= 1'b1;
		end else if (wr_req) begin
			mod_req_r <= PWDATA_I[REQ_MOD_BIT];
		end else if (mod_acc) begin
			mod_req_r <= 1'b0;
		end
	end

	// enables and disabled state; for the disabled state, acceptance beats a coinciding enable write
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ints_dis_r <= 1'b1;
			ie_tick_r  <= 1'b0;
			ie_mod_r   <= 1'b0;
		end else begin
			if (wr_en) begin
				ie_tick_r <= PWDATA_I[EN_TICK_BIT];
				ie_mod_r  <= PWDATA_I[EN_MOD_BIT];
			end
			if (tick_acc || mod_acc) begin
				ints_dis_r <= 1'b1;
			end else if (wr_en) begin
				ints_dis_r <= ~PWDATA_I[EN_ALL_BIT];
			end
		end
	end

	// acceptance pulses out
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			TICK_INT_O <= 1'b0;
			MOD_INT_O  <= 1'b0;
		end else begin
			TICK_INT_O <= tick_acc;
			MOD_INT_O  <= mod_acc;
		end
	end
	assign INTS_DISABLED_O = ints_dis_r;

	// checks
	sequence slow_read_s;
		rd_slow && !slow_evt;
	endsequence
	sequence mod_step_s;
		run_r && mod_clk_en && !clr_wr;
	endsequence

	slow_set_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		slow_evt |=> slow_flag_r) else $error("slow tick did not set the flag");
	slow_clear_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		slow_read_s |=> !slow_flag_r && PREADY_O) else $error("slow flag read did not clear");
	slow_prio_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		rd_slow && slow_evt |=> slow_flag_r) else $error("slow tick lost to read clear");
	tick_fall_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		tick_fall && !wr_req |=> tick_req_r) else $error("pulse fall did not set request");
	clear_wins_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		tick_fall && wr_req && !PWDATA_I[REQ_TICK_BIT] |=> !tick_req_r && !TICK_INT_O)
		else $error("clear did not win over pulse fall");
	accept_gate_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		TICK_INT_O |-> $past(tick_req_r) && !$past(ints_dis_r) && $past(ie_tick_r))
		else $error("tick accepted without its enables");
	accept_di_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		tick_acc |=> ints_dis_r && TICK_INT_O) else $error("acceptance did not disable");
	mod_wrap_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		mod_step_s ##0 (cnt_r == cmp_r) |=> cnt_r == 8'h00 && mod_req_r)
		else $error("match did not restart the count");
	mod_hold_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		!run_r && !clr_wr |=> $stable(cnt_r)) else $error("stopped counter moved");
	clr_read_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		rd_go && reg_hit(PADDR_I, IDX_MOD_CTRL) |=> !PRDATA_O[CTRL_CLR_BIT])
		else $error("clear bit read back as one");
endmodule : tmt_top

`default_nettype wire

// [hdl/tmt_pkg.sv]
// package for the tick and modulo timer block: register indices, fields, resets, timing
// assumes a 125 MHz core clock and the 75 kHz timer base derived from it
`default_nettype none

package tmt_pkg;

	// core clock and timer base rates
	localparam int CLK_HZ        = 125_000_000;
	localparam int SYS_HZ        = 75_000;
	localparam int SYS_KHZ       = 75;
	localparam int MOD_SLOW_KHZ  = 25;
	// periods as printed, in ms
	localparam int SLOW_TICK_MS  = 125;
	localparam int TICK_SLOW_MS  = 32;
	localparam int TICK_FAST_MS  = 8;
	// derived counts: core cycles per base tick, base ticks per period, fast intervals per slow interval
	localparam int SYS_DIV_CYC   = CLK_HZ / SYS_HZ;
	localparam int SLOW_TICKS    = SLOW_TICK_MS * SYS_KHZ;
	localparam int TICK_FAST_CNT = TICK_FAST_MS * SYS_KHZ;
	localparam int TICK_RATIO    = TICK_SLOW_MS / TICK_FAST_MS;
	localparam int MOD_SLOW_DIV  = SYS_KHZ / MOD_SLOW_KHZ;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_SLOW_FLAG = 8'h17;
	localparam logic [7:0] IDX_RATE_SEL  = 8'h18;
	localparam logic [7:0] IDX_MOD_CMP   = 8'h1a;
	localparam logic [7:0] IDX_MOD_CNT   = 8'h1b;
	localparam logic [7:0] IDX_MOD_CTRL  = 8'h2b;
	localparam logic [7:0] IDX_IRQ_REQ   = 8'h30;
	localparam logic [7:0] IDX_IRQ_EN    = 8'h31;

	// field positions
	localparam int RATE_SEL_BIT  = 0;
	localparam int CTRL_RUN_BIT  = 3;
	localparam int CTRL_CLR_BIT  = 2;
	localparam int CTRL_SEL_HI   = 1;
	localparam int CTRL_SEL_LO   = 0;
	localparam int REQ_TICK_BIT  = 0;
	localparam int REQ_MOD_BIT   = 1;
	localparam int EN_ALL_BIT    = 0;
	localparam int EN_TICK_BIT   = 1;
	localparam int EN_MOD_BIT    = 2;

	// reset values
	localparam logic       SLOW_FLAG_RST = 1'b1;
	localparam logic       RATE_SEL_RST  = 1'b0;
	localparam logic [1:0] CTRL_SEL_RST  = 2'h0;
	localparam logic       CTRL_RUN_RST  = 1'b0;
	localparam logic [7:0] MOD_CMP_RST   = 8'hff;
	localparam logic [7:0] MOD_CNT_RST   = 8'h00;

	// modulo clock source codes
	typedef enum logic [1:0] {
		TMT_SRC_EXT_A = 2'h0,
		TMT_SRC_EXT_B = 2'h1,
		TMT_SRC_75K   = 2'h2,
		TMT_SRC_25K   = 2'h3
	} tmt_src_t;

endpackage : tmt_pkg

`default_nettype wire

// [hdl/tmt_sync.sv]
// three-flop synchroniser for an asynchronous count pin
// assumes one core clock; output moves only when flops two and three agree
`timescale 1ns/10ps
`default_nettype none

module tmt_sync (
	input  wire logic clk_i,     // core clock
	input  wire logic rstn_i,    // async reset, active low
	input  wire logic async_i,   // pin level
	output logic      level_o    // filtered level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// shift chain, first flop feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accept a change once two and three agree
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_o <= s3_r;
		end
	end
endmodule : tmt_sync

`default_nettype wire

// [hdl/tmt_div.sv]
// enable-driven modulo divider, counts 0..N-1 and pulses on the wrap
// assumes en_i is a one-cycle enable in the core clock domain
`timescale 1ns/10ps
`default_nettype none

module tmt_div #(
	parameter int N = 4                        // division ratio
) (
	input  wire logic                 clk_i,   // core clock
	input  wire logic                 rstn_i,  // async reset, active low
	input  wire logic                 en_i,    // count enable
	output logic [$clog2(N+1)-1:0]    cnt_o,   // current phase
	output logic                      tick_o   // wrap pulse
);
	localparam int W = $clog2(N + 1);
	localparam logic [W-1:0] LAST = W'(N - 1);

	// wrap pulse is the enable seen at the last phase
	assign tick_o = en_i & (cnt_o == LAST);

	// phase counter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_o <= '0;
		end else if (tick_o) begin
			cnt_o <= '0;
		end else if (en_i) begin
			cnt_o <= cnt_o + W'(1);
		end
	end
endmodule : tmt_div

`default_nettype wire

// [testbench/tb_tmt.sv]
// self-checking bench for the tick and modulo timers, driven over apb
// assumes tmt_pkg and tmt_top are compiled first; short timing parameters are used
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
$display("unexpected %s expected %0h seen %0h", nm, ex, gt); fail_count++; end end

module testbench;
	import tmt_pkg::*;
	localparam int SDIV   = 4;
	localparam int SCNT   = 20;
	localparam int FCNT   = 8;
	localparam int SLOW_P = SDIV * SCNT;
	localparam int FAST_P = SDIV * FCNT;
	localparam logic [11:0] A_SLOW = {2'h0, IDX_SLOW_FLAG, 2'h0};
	localparam logic [11:0] A_RATE = {2'h0, IDX_RATE_SEL, 2'h0};
	localparam logic [11:0] A_CMP  = {2'h0, IDX_MOD_CMP, 2'h0};
	localparam logic [11:0] A_CNT  = {2'h0, IDX_MOD_CNT, 2'h0};
	localparam logic [11:0] A_CTRL = {2'h0, IDX_MOD_CTRL, 2'h0};
	localparam logic [11:0] A_REQ  = {2'h0, IDX_IRQ_REQ, 2'h0};
	localparam logic [11:0] A_EN   = {2'h0, IDX_IRQ_EN, 2'h0};
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] wd;
		logic [31:0] rd;
		logic        er;
	} tmtb_row_t;

	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_a;
	logic        ext_b;
	logic        tick_int;
	logic        mod_int;
	logic        ints_dis;
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          cyc        = 0;
	int          tick_n     = 0;
	int          mod_n      = 0;
	logic [31:0] v;
	logic [31:0] v1;
	logic        e;
	int          t0;
	int          t1;
	// plain accesses: address, write data, expected read, expected error
	tmtb_row_t   rows [10] = '{
		'{A_RATE, 32'h1, 32'h1, 1'b0}, '{A_RATE, 32'hffff_fffe, 32'h0, 1'b0},
		'{A_CMP, 32'h55, 32'h0, 1'b0}, '{A_CNT, 32'h77, 32'h0, 1'b0},
		'{A_CTRL, 32'h7, 32'h3, 1'b0}, '{A_CTRL, 32'h0, 32'h0, 1'b0},
		'{A_EN, 32'h6, 32'h6, 1'b0}, '{A_EN, 32'h0, 32'h0, 1'b0},
		'{12'h000, 32'h1, 32'h0, 1'b1}, '{12'h061, 32'h1, 32'h0, 1'b1}};

	tmt_top #(.SYS_DIV(SDIV), .SLOW_CNT(SCNT), .FAST_CNT(FCNT)) i_tmt_top (
		.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_COUNT_A_I(ext_a),
		.EXT_COUNT_B_I(ext_b), .TICK_INT_O(tick_int), .MOD_INT_O(mod_int),
		.INTS_DISABLED_O(ints_dis));

	// free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// cycle stamp and accepted-interrupt pulse counts
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tick_int === 1'b1) tick_n <= tick_n + 1;
		if (mod_int === 1'b1) mod_n <= mod_n + 1;
	end

	// prints the counts and the verdict, then ends the run
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	// one apb transfer: setup, access held until pready sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			$display("unexpected pready timeout expected 1 seen 0");
			fail_count++;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        r;
		apb(1'b1, a, d, q, r);
	endtask : wr

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
		logic [31:0] d;
		logic        r;
		apb(1'b0, a, 32'h0, d, r);
		`CHK(nm, ex, d)
	endtask : rchk

	// read until bit b is set, stamp the cycle, optionally clear by writing 0
	task automatic poll(input logic [11:0] a, input int b, input logic clr, output int t);
		logic [31:0] d;
		logic        r;
		int          n;
		n = 0;
		d = '0;
		while (d[b] !== 1'b1 && n < 200) begin
			apb(1'b0, a, 32'h0, d, r);
			n++;
		end
		t = cyc;
		if (n >= 200) begin
			$display("unexpected poll timeout expected 1 seen 0");
			fail_count++;
		end
		if (clr) wr(a, 32'h0);
	endtask : poll

	// n rising edges on count pin a (b low) or pin b (b high)
	task automatic pulse(input logic b, input int n);
		repeat (n) begin
			@(posedge clk);
			if (b) ext_b <= 1'b1;
			else ext_a <= 1'b1;
			repeat (6) @(posedge clk);
			ext_a <= 1'b0;
			ext_b <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask : pulse

	// watchdog, several times the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		$display("unexpected watchdog expected done seen timeout");
		fail_count++;
		give_verdict;
	end

	// main sequence
	initial begin
		rstn    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		ext_a   = 1'b0;
		ext_b   = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].wd, v, e);
			`CHK("write error", rows[i].er, e)
			apb(1'b0, rows[i].a, 32'h0, v, e);
			`CHK("read data", rows[i].rd, v)
			`CHK("read error", rows[i].er, e)
		end
		$display("done register table");
		// reset in mid-run after changing state
		wr(A_RATE, 32'h1);
		wr(A_CTRL, 32'ha);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rchk("slow after reset", A_SLOW, 32'h1);
		rchk("slow read clears", A_SLOW, 32'h0);
		rchk("rate after reset", A_RATE, 32'h0);
		rchk("ctrl after reset", A_CTRL, 32'h0);
		rchk("count after reset", A_CNT, 32'h0);
		$display("done reset");
		// slow tick period
		poll(A_SLOW, 0, 1'b0, t0);
		poll(A_SLOW, 0, 1'b0, t1);
		`CHK("slow period", 1'b1, (t1 - t0 >= SLOW_P - 8) && (t1 - t0 <= SLOW_P + 8))
		$display("done slow tick");
		// tick request period for both rates
		for (int r = 0; r < 2; r++) begin
			wr(A_REQ, 32'h0);
			wr(A_RATE, r);
			poll(A_REQ, 0, 1'b1, t0);
			poll(A_REQ, 0, 1'b1, t0);
			poll(A_REQ, 0, 1'b1, t1);
			t1 = t1 - t0 - (r ? FAST_P : FAST_P * TICK_RATIO);
			`CHK("tick period", 1'b1, (t1 >= -12) && (t1 <= 12))
		end
		// switch to the fast pulse while it is low and the slow one high
		wr(A_RATE, 32'h0);
		poll(A_REQ, 0, 1'b1, t0);
		poll(A_REQ, 0, 1'b1, t0);
		repeat (77) @(posedge clk);
		wr(A_RATE, 32'h1);
		rchk("request on switch", A_REQ, 32'h1);
		$display("done tick rates");
		// acceptance gating, acceptance on enable, ticks while disabled
		wr(A_EN, 32'h2);
		wr(A_REQ, 32'h1);
		t0 = tick_n;
		repeat (8) @(posedge clk);
		`CHK("accept while masked", t0, tick_n)
		wr(A_EN, 32'h3);
		repeat (4) @(posedge clk);
		`CHK("accept on enable", t0 + 1, tick_n)
		`CHK("disabled after accept", 1'b1, ints_dis)
		repeat (FAST_P + 8) @(posedge clk);
		rchk("request while disabled", A_REQ, 32'h1);
		`CHK("no second accept", t0 + 1, tick_n)
		// clears swept across every phase so one meets a pulse fall
		repeat (32) begin
			wr(A_REQ, 32'h0);
			@(posedge clk);
		end
		$display("done tick interrupt");
		// modulo wrap, match request, hold and clear
		wr(A_EN, 32'h0);
		wr(A_CMP, 32'h3);
		wr(A_CTRL, 32'he);
		v1 = '0;
		repeat (16) begin
			apb(1'b0, A_CNT, 32'h0, v, e);
			if (v > v1) v1 = v;
		end
		`CHK("count peak", 32'h3, v1)
		apb(1'b0, A_REQ, 32'h0, v, e);
		`CHK("match request", 1'b1, v[REQ_MOD_BIT])
		t0 = mod_n;
		wr(A_EN, 32'h5);
		repeat (4) @(posedge clk);
		`CHK("modulo accept", t0 + 1, mod_n)
		wr(A_EN, 32'h0);
		wr(A_CTRL, 32'h2);
		apb(1'b0, A_CNT, 32'h0, v1, e);
		repeat (40) @(posedge clk);
		wr(A_CTRL, 32'h2);
		rchk("count held", A_CNT, v1);
		wr(A_CTRL, 32'h6);
		rchk("count cleared", A_CNT, 32'h0);
		$display("done modulo counting");
		// count pins and internal sources
		wr(A_CMP, 32'hff);
		for (int s = 0; s < 2; s++) begin
			wr(A_CTRL, 32'hc | s);
			pulse(1'b0, 3);
			pulse(1'b1, 2);
			rchk("pin count", A_CNT, s ? 32'h2 : 32'h3);
		end
		for (int s = 2; s < 4; s++) begin
			wr(A_CTRL, 32'hc | s);
			repeat (120) @(posedge clk);
			apb(1'b0, A_CNT, 32'h0, v, e);
			t0 = 120 / (SDIV * (s == 2 ? 1 : MOD_SLOW_DIV));
			`CHK("source rate", 1'b1, (v >= t0 - 2) && (v <= t0 + 3))
		end
		$display("done clock sources");
		give_verdict;
	end
endmodule : testbench

`default_nettype wire
